// >>> shared/sfl_pkg.sv
// Purpose: Constants for the safety fault latch.
// Assumes: 200 MHz clock on clk_in.
// Notes: Long counts appear again as top-level parameters.
package sfl_pkg;
   // ********************************************
   // Timing
   // ********************************************
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned SET_PULSE_MS = 5;
   localparam int unsigned CLEAR_PULSE_MS = 5;
   localparam int unsigned RELAY_FAULT_MS = 2500;
   localparam int unsigned BRIDGE_FAULT_MS = 1500;
   // Cycles per millisecond at the clock rate
   localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
   // Least pulse widths round up; both are exact here
   localparam int unsigned SET_CYCLES = SET_PULSE_MS * CYC_PER_MS;
   localparam int unsigned CLEAR_CYCLES = CLEAR_PULSE_MS * CYC_PER_MS;
   localparam int unsigned RELAY_CYCLES = RELAY_FAULT_MS * CYC_PER_MS;
   localparam int unsigned BRIDGE_CYCLES = BRIDGE_FAULT_MS * CYC_PER_MS;
   localparam int CNT_W = 32;
   localparam logic LATCH_RESET_VAL = 1'h1;
   // ********************************************
   // Idle pin levels
   // ********************************************
   // Synchronisers reset to these so no false request follows reset
   localparam logic SET_IDLE = 1'h1;
   localparam logic CLEAR_IDLE = 1'h1;
   localparam logic CAP_IDLE = 1'h0;
   localparam logic RELAY_IDLE = 1'h0;
   localparam logic BRIDGE_IDLE = 1'h1;
   // ********************************************
   // Latch state
   // ********************************************
   typedef enum logic [0:0] {
      SFL_CLEARED = 1'h0,
      SFL_TRIPPED = 1'h1
   } sfl_state_type;
endpackage : sfl_pkg

// >>> rtl/sfl_persist.sv
// Purpose: Reports a condition held without a break for a given number of cycles.
// Assumes: Input already synchronised to clk_in.
// Notes: Any gap in the condition restarts the count.
module sfl_persist #(
   parameter logic [sfl_pkg::CNT_W-1:0] LIMIT = 32'h0000_0001
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic cond_in,
   output logic hit_out
);
   logic [sfl_pkg::CNT_W-1:0] count_reg;
   logic [sfl_pkg::CNT_W-1:0] count_next;
   logic [sfl_pkg::CNT_W-1:0] count_inc;
   logic hit_reg;
   wire at_limit = (count_reg >= LIMIT);
   // Counts this cycle's sample too, so a run of exactly LIMIT samples hits
   wire run_done = (count_inc >= LIMIT);

   assign count_inc = count_reg + 32'h0000_0001;
   // Saturate so a stuck condition never wraps back to idle
   assign count_next = !cond_in ? '0 : (at_limit ? count_reg : count_inc);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_reg <= '0;
         hit_reg <= 1'h0;
      end else begin
         count_reg <= count_next;
         hit_reg <= cond_in && run_done;
      end
   end

   assign hit_out = hit_reg;
endmodule : sfl_persist

// >>> rtl/sfl_latch.sv
// What this block does
// - A set pulse held low for the full 5 ms sets the safety latch at any time.
// - A clear pulse held low for the full 5 ms, with no trip source active, returns the latch to its cleared state.
// - A charge-not-stopped indication from the capacitor voltage monitor sets the latch.
// - Relay driver conduction lasting beyond 2.5 s sets the latch.
// - Bridge fault indication held low beyond 1.5 s sets the latch.
// - The latched-fault output is high while the latch is set and low while cleared.
//
// Purpose: Safety fault latch of the high-voltage unit.
// Assumes: Fault senses are comparator outputs from outside the clock domain.
// Notes: Latch comes out of reset set, failing safe until cleared.
module sfl_latch #(
   parameter logic [sfl_pkg::CNT_W-1:0] SET_CYCLES = sfl_pkg::SET_CYCLES,
   parameter logic [sfl_pkg::CNT_W-1:0] CLEAR_CYCLES = sfl_pkg::CLEAR_CYCLES,
   parameter logic [sfl_pkg::CNT_W-1:0] RELAY_CYCLES = sfl_pkg::RELAY_CYCLES,
   parameter logic [sfl_pkg::CNT_W-1:0] BRIDGE_CYCLES = sfl_pkg::BRIDGE_CYCLES
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic latch_set_n_in,
   input wire logic latch_clear_n_in,
   input wire logic cap_voltage_sense_in,
   input wire logic relay_driver_fault_sense_in,
   input wire logic bridge_fault_sense_n_in,
   output logic fault_latched_out
);
   // ********************************************
   // Input synchronisers
   // ********************************************
   // Set and clear idle high, so they reset high
   // Two stages per pin; nothing but the second stage is read
   logic set_meta_reg;
   logic set_sync_reg;
   logic clear_meta_reg;
   logic clear_sync_reg;
   logic cap_meta_reg;
   logic cap_sync_reg;
   logic relay_meta_reg;
   logic relay_sync_reg;
   logic bridge_meta_reg;
   logic bridge_sync_reg;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         set_meta_reg <= sfl_pkg::SET_IDLE;
         set_sync_reg <= sfl_pkg::SET_IDLE;
      end else begin
         set_meta_reg <= latch_set_n_in;
         set_sync_reg <= set_meta_reg;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clear_meta_reg <= sfl_pkg::CLEAR_IDLE;
         clear_sync_reg <= sfl_pkg::CLEAR_IDLE;
      end else begin
         clear_meta_reg <= latch_clear_n_in;
         clear_sync_reg <= clear_meta_reg;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cap_meta_reg <= sfl_pkg::CAP_IDLE;
         cap_sync_reg <= sfl_pkg::CAP_IDLE;
      end else begin
         cap_meta_reg <= cap_voltage_sense_in;
         cap_sync_reg <= cap_meta_reg;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         relay_meta_reg <= sfl_pkg::RELAY_IDLE;
         relay_sync_reg <= sfl_pkg::RELAY_IDLE;
      end else begin
         relay_meta_reg <= relay_driver_fault_sense_in;
         relay_sync_reg <= relay_meta_reg;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bridge_meta_reg <= sfl_pkg::BRIDGE_IDLE;
         bridge_sync_reg <= sfl_pkg::BRIDGE_IDLE;
      end else begin
         bridge_meta_reg <= bridge_fault_sense_n_in;
         bridge_sync_reg <= bridge_meta_reg;
      end
   end

   // ********************************************
   // Active levels
   // ********************************************
   // One polarity for every qualifier: high means asserted
   function automatic logic asserted_low(input logic level);
      asserted_low = (level == 1'h0);
   endfunction : asserted_low

   function automatic logic is_tripped(input sfl_pkg::sfl_state_type state);
      is_tripped = (state == sfl_pkg::SFL_TRIPPED);
   endfunction : is_tripped

   logic set_req;
   logic clear_req;
   logic cap_fault;
   logic relay_on;
   logic bridge_on;

   assign set_req = asserted_low(set_sync_reg);
   assign clear_req = asserted_low(clear_sync_reg);
   assign cap_fault = cap_sync_reg;
   assign relay_on = relay_sync_reg;
   assign bridge_on = asserted_low(bridge_sync_reg);

   // ********************************************
   // Qualifiers
   // ********************************************
   // Width check rejects glitches on the control lines
   logic set_hit;
   logic clear_hit;
   logic relay_hit;
   logic bridge_hit;

   sfl_persist #(
      .LIMIT(SET_CYCLES)
   ) u_set (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .cond_in(set_req),
      .hit_out(set_hit)
   );

   sfl_persist #(
      .LIMIT(CLEAR_CYCLES)
   ) u_clear (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .cond_in(clear_req),
      .hit_out(clear_hit)
   );

   sfl_persist #(
      .LIMIT(RELAY_CYCLES)
   ) u_relay (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .cond_in(relay_on),
      .hit_out(relay_hit)
   );

   sfl_persist #(
      .LIMIT(BRIDGE_CYCLES)
   ) u_bridge (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .cond_in(bridge_on),
      .hit_out(bridge_hit)
   );

   // ********************************************
   // Latch
   // ********************************************
   sfl_pkg::sfl_state_type state_reg;
   sfl_pkg::sfl_state_type state_next;

   logic trip;
   logic release_ok;
   logic fault_next;

   // Any trip source beats a clear in the same cycle
   assign trip = set_hit
      || cap_fault
      || relay_hit
      || bridge_hit;
   assign release_ok = clear_hit && !trip;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sfl_pkg::SFL_CLEARED: begin
            if (trip) begin
               state_next = sfl_pkg::SFL_TRIPPED;
            end else begin
               state_next = sfl_pkg::SFL_CLEARED;
            end
         end
         sfl_pkg::SFL_TRIPPED: begin
            // Holds until cleared; fault going away is ignored
            if (release_ok) begin
               state_next = sfl_pkg::SFL_CLEARED;
            end else begin
               state_next = sfl_pkg::SFL_TRIPPED;
            end
         end
         default: begin
            // Unknown code fails safe
            state_next = sfl_pkg::SFL_TRIPPED;
         end
      endcase
   end

   assign fault_next = is_tripped(state_next);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= sfl_pkg::SFL_TRIPPED;
      end else begin
         state_reg <= state_next;
      end
   end

   // Registered so the pin never shows a decode glitch
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fault_latched_out <= sfl_pkg::LATCH_RESET_VAL;
      end else begin
         fault_latched_out <= fault_next;
      end
   end
endmodule : sfl_latch

// >>> verification/sfl_checker.sv
// Purpose: Port assertions for sfl_latch
// Assumes: Idle set/clear/bridge high
// Notes: Run counters replace long repeats
module sfl_checker #(
   parameter logic [31:0] SET_CYCLES = 32'h4,
   parameter logic [31:0] CLEAR_CYCLES = 32'h4,
   parameter logic [31:0] RELAY_CYCLES = 32'h8,
   parameter logic [31:0] BRIDGE_CYCLES = 32'h6
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic latch_set_n_in,
   input wire logic latch_clear_n_in,
   input wire logic cap_voltage_sense_in,
   input wire logic relay_driver_fault_sense_in,
   input wire logic bridge_fault_sense_n_in,
   input wire logic fault_latched_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Run counters, quiet span guards clear
   // ********
   logic [31:0] sr, cr, rr, br, qt, sc;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sr <= '0;
         cr <= '0;
         rr <= '0;
         br <= '0;
         sc <= '0;
         qt <= '0;
      end else begin
      sr <= latch_set_n_in ? '0 : sr + 1;
      cr <= latch_clear_n_in ? '0 : cr + 1;
      rr <= relay_driver_fault_sense_in ? rr + 1 : '0;
      br <= bridge_fault_sense_n_in ? '0 : br + 1;
      sc <= latch_clear_n_in ? sc + 1 : '0;
      qt <= (cap_voltage_sense_in | relay_driver_fault_sense_in | !bridge_fault_sense_n_in
         | !latch_set_n_in) ? '0 : qt + 1;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   AST_SET: assert property (sr == SET_CYCLES |-> ##[0:5] fault_latched_out)
      else $error("set missed");
   AST_CLR: assert property (cr == CLEAR_CYCLES && qt > CLEAR_CYCLES + 32'h8
      |-> ##[0:5] !fault_latched_out) else $error("clear missed");
   AST_CAP: assert property (cap_voltage_sense_in |-> ##[1:4] fault_latched_out)
      else $error("cap trip missed");
   AST_RLY: assert property (rr == RELAY_CYCLES |-> ##[0:5] fault_latched_out)
      else $error("relay trip missed");
   AST_BRG: assert property (br == BRIDGE_CYCLES |-> ##[0:5] fault_latched_out)
      else $error("bridge trip missed");
   AST_CAUSE: assert property ($rose(fault_latched_out) |-> qt < 32'h6)
      else $error("trip without cause");
   AST_HOLD: assert property ($fell(fault_latched_out) |-> sc < 32'h6)
      else $error("latch dropped");
   cover property (cr == CLEAR_CYCLES);
   cover property ($rose(fault_latched_out));
   cover property (cap_voltage_sense_in && !latch_clear_n_in);
endmodule : sfl_checker
bind sfl_latch sfl_checker #(.SET_CYCLES(SET_CYCLES), .CLEAR_CYCLES(CLEAR_CYCLES),
   .RELAY_CYCLES(RELAY_CYCLES), .BRIDGE_CYCLES(BRIDGE_CYCLES)) u_chk (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .latch_set_n_in(latch_set_n_in),
   .latch_clear_n_in(latch_clear_n_in), .cap_voltage_sense_in(cap_voltage_sense_in),
   .relay_driver_fault_sense_in(relay_driver_fault_sense_in),
   .bridge_fault_sense_n_in(bridge_fault_sense_n_in), .fault_latched_out(fault_latched_out));

// >>> verification/sfl_ctrl_model.sv
// Purpose: Controller and comparator stand-in
// Assumes: Called from one process
// Notes: Released lines return to idle
module sfl_ctrl_model (
   input wire logic clk_in,
   output logic s_n_out,
   output logic c_n_out,
   output logic cap_out,
   output logic rly_out,
   output logic b_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic drive(input int sel, input logic act);
      case (sel)
         0: s_n_out = !act;
         1: c_n_out = !act;
         2: cap_out = act;
         3: rly_out = act;
         default: b_n_out = !act;
      endcase
   endtask : drive
   task automatic pulse(input int sel, input int len);
      @(negedge clk_in);
      drive(sel, 1'h1);
      repeat (len) @(negedge clk_in);
      drive(sel, 1'h0);
   endtask : pulse
   initial for (int i = 0; i < 5; i++) drive(i, 1'h0);
endmodule : sfl_ctrl_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for sfl_latch
// Assumes: Short counts via parameters
// Notes: Rows hold a pulse and the level left
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 4, CC = 4, RC = 8, BC = 6;
   typedef struct {int sel; int len; logic exp;} sfl_row_type;
   sfl_row_type rows[14] = '{'{0, SC, 1'h1}, '{1, CC, 1'h0}, '{0, SC - 1, 1'h0},
      '{0, SC, 1'h1}, '{1, CC - 1, 1'h1}, '{1, CC, 1'h0}, '{3, RC - 1, 1'h0}, '{3, RC, 1'h1},
      '{1, CC, 1'h0}, '{4, BC - 1, 1'h0}, '{4, BC, 1'h1}, '{1, CC, 1'h0}, '{2, 1, 1'h1},
      '{1, CC, 1'h0}};
   logic clk_in, arst_n_in, fo;
   wire logic s_n, c_n, cap, rly, b_n;
   int fail_count, cmp_count;
   sfl_latch #(.SET_CYCLES(SC), .CLEAR_CYCLES(CC), .RELAY_CYCLES(RC), .BRIDGE_CYCLES(BC))
      DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .latch_set_n_in(s_n),
      .latch_clear_n_in(c_n), .cap_voltage_sense_in(cap), .relay_driver_fault_sense_in(rly),
      .bridge_fault_sense_n_in(b_n), .fault_latched_out(fo));
   sfl_ctrl_model ctrl (.clk_in(clk_in), .s_n_out(s_n), .c_n_out(c_n), .cap_out(cap),
      .rly_out(rly), .b_n_out(b_n));
   task automatic check_out(input logic exp);
      cmp_count++;
      if (fo !== exp) begin
         fail_count++;
         $display("CHECK FAILED fault_latched_out exp %b got %b", exp, fo);
      end
   endtask : check_out
   task automatic report_and_stop();
      $display("fails %0d compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial begin
      clk_in = 1'h0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial begin
      #20us;
      fail_count++;
      report_and_stop();
   end
   initial begin
      arst_n_in = 1'h0;
      repeat (8) @(negedge clk_in);
      check_out(1'h1);
      arst_n_in = 1'h1;
      foreach (rows[i]) begin
         ctrl.pulse(rows[i].sel, rows[i].len);
         repeat (16) @(negedge clk_in);
         check_out(rows[i].exp);
      end
      // Trip held during clear must win
      ctrl.drive(2, 1'h1);
      ctrl.pulse(1, CC);
      repeat (16) @(negedge clk_in);
      check_out(1'h1);
      ctrl.drive(2, 1'h0);
      ctrl.pulse(1, CC);
      repeat (16) @(negedge clk_in);
      check_out(1'h0);
      arst_n_in = 1'h0;
      #1;
      check_out(1'h1);
      report_and_stop();
   end
endmodule : tb_top
